// ### common/drdm_pkg.sv
// Purpose: Shared constants and carriers for the DRAM row decode and memory map block
// Assumes: AXI4-Lite register port, 32-bit data, host address 32 bits
// Notes:   Printed offsets are not all multiples of four, so they are indices
package drdm_pkg;

  // ----------------------------------------------------------------
  // Register word indices, counts and address width
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_ROW_LIMIT_0     = 8'h60;
  localparam logic [7:0]  IDX_ROW_LIMIT_7     = 8'h67;
  localparam logic [7:0]  IDX_ROW_KIND_SELECT = 8'h68;
  localparam logic [7:0]  IDX_SEG_ATTR_0      = 8'h70;
  localparam logic [7:0]  IDX_SEG_ATTR_1      = 8'h71;
  localparam int          NUM_ROWS            = 8;
  localparam int          NUM_SEGS            = 13;
  localparam int          ADDR_W              = 12;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ROW_LIMIT_RST       = 8'h02;
  localparam logic [7:0]  ROW_KIND_RST        = 8'h00;
  localparam logic [3:0]  SEG_ATTR_RST        = 4'h0;

  // ----------------------------------------------------------------
  // Attribute field layout
  // ----------------------------------------------------------------
  localparam int          ATTR_READ_BIT       = 0;
  localparam int          ATTR_WRITE_BIT      = 1;
  localparam int          ATTR_CACHE_BIT      = 2;

  // ----------------------------------------------------------------
  // Map limits, in A[31:14] 16-Kbyte units except where noted
  // ----------------------------------------------------------------
  localparam logic [17:0] SEG_EXP_BASE        = 18'h00030;
  localparam logic [17:0] SEG_FW_BASE         = 18'h0003c;
  localparam logic [17:0] SEG_FW_END          = 18'h00040;
  localparam logic [12:0] TOP_FLASH_PAGE      = 13'h1fff;
  localparam logic [8:0]  DRAM_CAP_4MB        = 9'h080;
  localparam logic [1:0]  RESP_OKAY           = 2'b00;
  localparam logic [1:0]  RESP_SLVERR         = 2'b10;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        from_pci;
    logic [31:0] addr;
  } drdm_req_t;

  typedef struct packed {
    logic       valid;
    logic       to_dram;
    logic       to_pci;
    logic       pci_claim;
    logic       cacheable;
    logic [7:0] row_strobe_n;
    logic       edo_timing;
  } drdm_dec_t;

  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_WRESP = 3'b010,
    BUS_RDATA = 3'b100
  } drdm_bus_state_t;

endpackage : drdm_pkg

// ### rtl/drdm_decode.sv
// Purpose: Host address decoder: legacy segments, extended memory, DRAM row select
// Assumes: One clock aclk, synchronous active-low reset, one request per cycle
// Notes:   Decision registered one cycle after the request; timing engine is outside
//
// Behaviour
// - Expansion range splits into eight 16K segments, each with own attributes.
// - Disabled expansion segment leaves its DRAM unreachable, never relocated.
// - Extended firmware range splits into four 16K segments, own attributes.
// - Firmware range F0000-FFFFF is one 64K segment, own attributes, not relocated.
// - Top 512 Kbytes below 4 Gbytes always go to PCI.
// - DRAM mapped from 1 Mbyte up to 512 Mbytes, and cacheable.
// - Top of DRAM up to 4 Gbytes is PCI memory, never cacheable.
// - Eight 64-bit rows, each with its own row strobe.
// - Each row holds an 8-bit cumulative upper limit in 4-Mbyte units.
// - Row limits are compared against host address bits A[29:22].
// - Strobe only when address is at or above previous limit and below own.
// - Row with limit equal to previous limit is empty, never strobed.
// - Top of DRAM is row 7 limit, capped at 512 Mbytes.
// - One type bit per row: 0 page mode, 1 extended data out.
// - Targeted row type bit picks timing before each DRAM cycle.
// - Each segment has a 4-bit field of read, write and cache permits.
// - Host write to read-only or read to unreadable segment goes to PCI.
// - PCI master access lacking permission is not claimed.
`timescale 1ns/1ns
module drdm_decode
  import drdm_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  input  wire drdm_req_t         req,
  output drdm_dec_t              dec
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    drdm_bus_state_t             wst;
    drdm_bus_state_t             rst;
    logic                        aw_have;
    logic                        w_have;
    logic [ADDR_W-1:0]           awaddr;
    logic [31:0]                 wdata;
    logic [3:0]                  wstrb;
    logic [1:0]                  bresp;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
    logic [NUM_ROWS-1:0][7:0]    row_limit;
    logic [7:0]                  row_kind_select;
    logic [NUM_SEGS-1:0][3:0]    segment_attribute;
    drdm_dec_t                   dec;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic                        arready;
    logic                        rvalid;
  } drdm_state_t;

  drdm_state_t s_q;
  drdm_state_t s_d;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Word index from byte address; bits 1:0 ignored
  function automatic logic [7:0] widx(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction : widx

  function automatic logic reg_hit(input logic [7:0] i);
    return (i >= IDX_ROW_LIMIT_0 && i <= IDX_ROW_KIND_SELECT)
        || i == IDX_SEG_ATTR_0 || i == IDX_SEG_ATTR_1;
  endfunction : reg_hit

  // Row strobe vector for A[29:22]; empty rows fall out of the compare
  logic [NUM_ROWS-1:0] row_hit;
  logic [7:0]          addr_4mb;
  assign addr_4mb = req.addr[29:22];

  genvar g;
  generate
    for (g = 0; g < NUM_ROWS; g++) begin : g_row
      if (g == 0) begin : g_first
        assign row_hit[g] = addr_4mb < s_q.row_limit[g];
      end else begin : g_rest
        assign row_hit[g] = addr_4mb >= s_q.row_limit[g-1]
                         && addr_4mb <  s_q.row_limit[g];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [17:0] page16k;
    logic [8:0]  top_4mb;
    logic        in_dram;
    logic        seg_hit;
    logic [3:0]  attr;
    logic        permit;
    logic [7:0]  wi;
    logic [7:0]  ri;
    logic [31:0] rv;
    s_d     = s_q;
    page16k = req.addr[31:14];
    seg_hit = 1'b0;
    attr    = SEG_ATTR_RST;
    permit  = 1'b0;
    rv      = 32'h0000_0000;
    wi      = 8'h00;
    ri      = 8'h00;

    // Top of DRAM in 4-Mbyte units, never above the cap
    top_4mb = ({1'b0, s_q.row_limit[NUM_ROWS-1]} > DRAM_CAP_4MB)
            ? DRAM_CAP_4MB : {1'b0, s_q.row_limit[NUM_ROWS-1]};
    // Addresses past 1 Gbyte alias A[29:22], so qualify the upper bits too
    in_dram = req.addr[31:30] == 2'b00
           && {1'b0, req.addr[29:22]} < top_4mb;

    // Segment lookup: C0000-EFFFF in 16K steps, F0000-FFFFF as one block
    if (page16k >= SEG_EXP_BASE && page16k < SEG_FW_BASE) begin
      seg_hit = 1'b1;
      attr    = s_q.segment_attribute[4'(page16k - SEG_EXP_BASE)];
    end else if (page16k >= SEG_FW_BASE && page16k < SEG_FW_END) begin
      seg_hit = 1'b1;
      attr    = s_q.segment_attribute[NUM_SEGS-1];
    end
    permit = req.write ? attr[ATTR_WRITE_BIT] : attr[ATTR_READ_BIT];

    s_d.dec.valid        = req.valid;
    s_d.dec.row_strobe_n = 8'hff;
    s_d.dec.to_dram      = 1'b0;
    s_d.dec.to_pci       = 1'b0;
    s_d.dec.pci_claim    = 1'b0;
    s_d.dec.cacheable    = 1'b0;
    s_d.dec.edo_timing   = 1'b0;
    if (req.valid) begin
      if (req.addr[31:19] == TOP_FLASH_PAGE) begin
        s_d.dec.to_pci = !req.from_pci;
      end else if (seg_hit) begin
        // Disabled or forbidden segment: DRAM unreachable, no relocation
        s_d.dec.to_dram   = permit;
        s_d.dec.to_pci    = !permit && !req.from_pci;
        s_d.dec.pci_claim = permit && req.from_pci;
        s_d.dec.cacheable = permit && attr[ATTR_CACHE_BIT];
      end else if (in_dram) begin
        s_d.dec.to_dram   = 1'b1;
        s_d.dec.pci_claim = req.from_pci;
        s_d.dec.cacheable = 1'b1;
      end else begin
        s_d.dec.to_pci = !req.from_pci;
      end
      if (s_d.dec.to_dram) begin
        s_d.dec.row_strobe_n = ~row_hit;
        s_d.dec.edo_timing   = |(row_hit & s_q.row_kind_select);
      end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    if (s_axi_awvalid && !s_q.aw_have && s_q.wst == BUS_IDLE) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_have && s_q.wst == BUS_IDLE) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end
    unique case (s_q.wst)
      BUS_IDLE: begin
        if (s_q.aw_have && s_q.w_have) begin
          wi          = widx(s_q.awaddr);
          s_d.bresp   = reg_hit(wi) ? RESP_OKAY : RESP_SLVERR;
          if (s_q.wstrb[0]) begin
            if (wi >= IDX_ROW_LIMIT_0 && wi <= IDX_ROW_LIMIT_7) begin
              s_d.row_limit[3'(wi - IDX_ROW_LIMIT_0)] = s_q.wdata[7:0];
            end else if (wi == IDX_ROW_KIND_SELECT) begin
              s_d.row_kind_select = s_q.wdata[7:0];
            end
          end
          for (int k = 0; k < 8; k++) begin
            if (s_q.wstrb[k/2] && wi == IDX_SEG_ATTR_0) begin
              s_d.segment_attribute[k] = s_q.wdata[k*4 +: 4];
            end
          end
          // Second word holds only five nibbles; the loop stops there
          for (int k = 0; k < NUM_SEGS - 8; k++) begin
            if (s_q.wstrb[k/2] && wi == IDX_SEG_ATTR_1) begin
              s_d.segment_attribute[k+8] = s_q.wdata[k*4 +: 4];
            end
          end
          s_d.aw_have = 1'b0;
          s_d.w_have  = 1'b0;
          s_d.wst     = BUS_WRESP;
        end
      end
      BUS_WRESP: begin
        if (s_axi_bready) begin
          s_d.wst = BUS_IDLE;
        end
      end
      BUS_RDATA: s_d.wst = BUS_IDLE;
      default:   s_d.wst = BUS_IDLE;
    endcase

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    unique case (s_q.rst)
      BUS_IDLE: begin
        if (s_axi_arvalid) begin
          ri = widx(s_axi_araddr);
          if (ri >= IDX_ROW_LIMIT_0 && ri <= IDX_ROW_LIMIT_7) begin
            rv[7:0] = s_q.row_limit[3'(ri - IDX_ROW_LIMIT_0)];
          end else if (ri == IDX_ROW_KIND_SELECT) begin
            rv[7:0] = s_q.row_kind_select;
          end else if (ri == IDX_SEG_ATTR_0) begin
            rv = s_q.segment_attribute[7:0];
          end else if (ri == IDX_SEG_ATTR_1) begin
            rv[19:0] = s_q.segment_attribute[NUM_SEGS-1:8];
          end
          s_d.rdata = rv;
          s_d.rresp = reg_hit(ri) ? RESP_OKAY : RESP_SLVERR;
          s_d.rst   = BUS_RDATA;
        end
      end
      BUS_RDATA: begin
        if (s_axi_rready) begin
          s_d.rst = BUS_IDLE;
        end
      end
      BUS_WRESP: s_d.rst = BUS_IDLE;
      default:   s_d.rst = BUS_IDLE;
    endcase

    // ----------------------------------------------------------------
    // Handshake flags, registered so every bus output is a flop
    // ----------------------------------------------------------------
    s_d.awready = !s_d.aw_have && s_d.wst == BUS_IDLE;
    s_d.wready  = !s_d.w_have && s_d.wst == BUS_IDLE;
    s_d.bvalid  = s_d.wst == BUS_WRESP;
    s_d.arready = s_d.rst == BUS_IDLE;
    s_d.rvalid  = s_d.rst == BUS_RDATA;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q                   <= '0;
      s_q.wst               <= BUS_IDLE;
      s_q.rst               <= BUS_IDLE;
      s_q.row_limit         <= {NUM_ROWS{ROW_LIMIT_RST}};
      s_q.row_kind_select   <= ROW_KIND_RST;
      s_q.segment_attribute <= {NUM_SEGS{SEG_ATTR_RST}};
      s_q.dec.row_strobe_n  <= 8'hff;
      // Readies come up high so the first request is taken at once
      s_q.awready           <= 1'b1;
      s_q.wready            <= 1'b1;
      s_q.arready           <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign dec           = s_q.dec;

endmodule : drdm_decode

// ### verification/drdm_chk.sv
// Purpose: Port-level checker for the DRAM row decode block
// Assumes: Decode answers one cycle after each request
// Notes:   Bound to the design top; sees its ports only
`timescale 1ns/1ns
module drdm_chk
  import drdm_pkg::*;
(
  input wire logic      aclk,
  input wire logic      aresetn,
  input wire logic      s_axi_arvalid,
  input wire logic      s_axi_arready,
  input wire logic      s_axi_rvalid,
  input wire drdm_req_t req,
  input wire drdm_dec_t dec
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_flash_req;
    req.valid && !req.from_pci && (req.addr[31:19] == TOP_FLASH_PAGE);
  endsequence
  sequence s_high_req;
    req.valid && !req.from_pci && (req.addr[31:30] != 2'b00);
  endsequence
  sequence s_pci_out;
    dec.to_pci && !dec.to_dram && (dec.row_strobe_n == 8'hff);
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_flash_to_pci: assert property (s_flash_req |=> s_pci_out)
    else $error("flash cycle not forwarded");
  a_high_no_cache: assert property (s_high_req |=> s_pci_out ##0 !dec.cacheable)
    else $error("high cycle cached or sent to dram");
  a_strobe_onehot: assert property (dec.valid |-> $onehot0(~dec.row_strobe_n))
    else $error("more than one row strobe");
  a_strobe_needs_dram: assert property (!dec.to_dram |-> dec.row_strobe_n == 8'hff)
    else $error("row strobe without dram route");
  a_dram_strobes: assert property (dec.to_dram |-> dec.row_strobe_n != 8'hff)
    else $error("dram route without row strobe");
  a_route_excl: assert property (dec.valid |-> !(dec.to_dram && dec.to_pci))
    else $error("cycle routed to both sides");
  a_dec_follows: assert property (req.valid |=> dec.valid)
    else $error("request not decoded next cycle");
  a_dec_quiet: assert property (!req.valid |=> !dec.valid)
    else $error("decode without request");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !dec.valid && dec.row_strobe_n == 8'hff) else $error("decode active in reset");
endmodule : drdm_chk

bind drdm_decode drdm_chk i_drdm_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .req, .dec);

// ### verification/drdm_host.sv
// Purpose: Host bus model issuing single memory cycles
// Assumes: Called just after a rising edge of aclk
// Notes:   A released bus shows inverted values, never the last ones
`timescale 1ns/1ns
module drdm_host
  import drdm_pkg::*;
(
  input  wire logic aclk,
  output drdm_req_t req
);
  // ----------------------------------------------------------------
  // Cycle driver
  // ----------------------------------------------------------------
  initial req = '0;
  // Held for exactly one sampling edge, as the decoder takes one per cycle
  task automatic cyc(input logic [31:0] a, input logic w, input logic p);
    req <= '{valid: 1'b1, write: w, from_pci: p, addr: a};
    @(posedge aclk);
    req <= '{valid: 1'b0, write: ~w, from_pci: ~p, addr: ~a};
  endtask : cyc
endmodule : drdm_host

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the DRAM row decode block
// Assumes: Bus answers within 50 cycles; bready and rready held high
// Notes:   Decode outputs sampled 1 ns after the answering edge
`timescale 1ns/1ns
module tb_top
  import drdm_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] KIND    = 8'ha5;
  localparam logic [7:0] LIM [8] = '{8'h02, 8'h02, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'hff};
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  drdm_req_t         req;
  drdm_dec_t         dec;
  int                err_count, total_checks;

  drdm_decode i_drdm_decode (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .req, .dec);
  drdm_host i_drdm_host (.aclk, .req);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic tmo(input int n);
    if (n >= 50) begin
      chk(32'h1, 32'h0);
      end_sim();
    end
  endtask : tmo
  // Address and data go out together; each is dropped at the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd;
    int   n;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(ad && wd && s_axi_bvalid) && n < 50);
    tmo(n);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad;
    int   n;
    ad = 1'b0;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!ad && s_axi_arready) begin
        ad = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end while (!(ad && s_axi_rvalid) && n < 50);
    tmo(n);
    chk(s_axi_rdata, d);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask : rd
  function automatic logic [12:0] ex(input logic d, input logic c, input logic [7:0] s,
                                     input logic t);
    return {1'b1, d, ~d, c, s, t};
  endfunction : ex
  // Timing bit only matters on a dram cycle, so it is masked elsewhere
  task automatic dc(input logic [31:0] a, input logic w, input logic p, input logic [12:0] e);
    i_drdm_host.cyc(a, w, p);
    #1;
    if (p) chk({31'h0, dec.pci_claim}, {31'h0, e[0]});
    else chk({19'h0, dec.valid, dec.to_dram, dec.to_pci, dec.cacheable, dec.row_strobe_n,
              dec.edo_timing & dec.to_dram}, {19'h0, e});
    @(posedge aclk);
  endtask : dc
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    err_count = 0;
    total_checks = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) rd(12'h180 + 12'(4 * i), 32'h2, RESP_OKAY);
    rd(12'h1a0, 32'h0, RESP_OKAY);
    rd(12'h004, 32'h0, RESP_SLVERR);
    wr(12'h17c, 32'hff, RESP_SLVERR);
    dc(32'h0010_0000, 0, 0, ex(1, 1, 8'hfe, 0));
    dc(32'h0080_0000, 0, 0, ex(0, 0, 8'hff, 0));
    for (int i = 0; i < 8; i++) wr(12'h180 + 12'(4 * i), 32'(i + 1), RESP_OKAY);
    wr(12'h1a0, {24'h0, KIND}, RESP_OKAY);
    rd(12'h19c, 32'h8, RESP_OKAY);
    for (int i = 0; i < 8; i++)
      dc((32'(i) << 22) + 32'h003f_fffc, 0, 0, ex(1, 1, ~(8'h1 << i), KIND[i]));
    dc(32'h0200_0000, 0, 0, ex(0, 0, 8'hff, 0));
    for (int i = 0; i < 8; i++) wr(12'h180 + 12'(4 * i), {24'h0, LIM[i]}, RESP_OKAY);
    dc(32'h0080_0000, 0, 0, ex(1, 1, 8'hfb, 1));
    dc(32'h0100_0000, 1, 0, ex(1, 1, 8'h7f, 1));
    dc(32'h1fff_fffc, 0, 0, ex(1, 1, 8'h7f, 1));
    dc(32'h2000_0000, 0, 0, ex(0, 0, 8'hff, 0));
    dc(32'h4000_0000, 0, 0, ex(0, 0, 8'hff, 0));
    dc(32'hfff8_0000, 0, 0, ex(0, 0, 8'hff, 0));
    wr(12'h1c0, 32'h0000_7201, RESP_OKAY);
    wr(12'h1c4, 32'h0003_0005, RESP_OKAY);
    rd(12'h1c0, 32'h0000_7201, RESP_OKAY);
    dc(32'h000c_0000, 0, 0, ex(1, 0, 8'hfe, 1));
    dc(32'h000c_0000, 1, 0, ex(0, 0, 8'hff, 0));
    dc(32'h000c_4000, 0, 0, ex(0, 0, 8'hff, 0));
    dc(32'h000c_8000, 1, 0, ex(1, 0, 8'hfe, 1));
    dc(32'h000c_c000, 0, 0, ex(1, 1, 8'hfe, 1));
    dc(32'h000e_0000, 0, 0, ex(1, 1, 8'hfe, 1));
    dc(32'h000e_4000, 0, 0, ex(0, 0, 8'hff, 0));
    dc(32'h000f_0000, 1, 0, ex(1, 0, 8'hfe, 1));
    dc(32'h000c_0000, 1, 1, 13'h0);
    dc(32'h000c_0000, 0, 1, 13'h1);
    dc(32'h000c_4000, 0, 1, 13'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h19c, 32'h2, RESP_OKAY);
    rd(12'h1a0, 32'h0, RESP_OKAY);
    rd(12'h1c0, 32'h0, RESP_OKAY);
    end_sim();
  end
endmodule : tb_top
